// file: smba_alu.sv
`include "smba_map.svh"
`default_nettype none
// Overview of operation
// RULE1: Byte left shift fills bit 0 with zero, old top bit to carry; 2/1 states.
// RULE2: Word left shift, same zero fill and carry capture; 2/1 states.
// RULE3: Byte arithmetic right shift keeps top bit, old bit 0 to carry; 2/1.
// RULE4: Word arithmetic right shift keeps sign, low bit to carry; 2/1 states.
// RULE5: Byte or word logical right shift fills top with zero; 2/1 states.
// RULE6: Nibble swap of accumulator, 2 states in either mode.
// RULE7: Accumulator times B, high byte to B, low to accumulator; 5 states.
// RULE8: Byte register multiply into double-width destination; 6/5 states.
// RULE9: Word register multiply gives 32-bit product; 12/11 states.
// RULE10: Accumulator divided by B, quotient to A, remainder to B; 10 states.
// RULE11: Register divide puts quotient in upper half of extended destination.
// RULE12: Register divide puts remainder in lower half of extended destination.
// RULE13: Byte register divide takes 11/10 states.
// RULE14: Word register divide takes 21/20 states.
// RULE15: Adjust adds 6 to low nibble above 9 or half carry; 1 state.
// RULE16: Then adds 6 to high nibble above 9 or carry set.
// RULE17: Mode input picks binary or source counts; done strobe at count end.
// RULE18: High nibble overflow sets carry, else carry kept from low step.
module smba_alu
    import smba_pkg::*;
(
    input  wire logic             CLK_SYS,
    input  wire logic             RESET_N,
    input  wire logic             START,
    input  wire smba_pkg::smba_req_t REQ,
    output logic                  BUSY,
    output logic                  DONE,
    output smba_pkg::smba_res_t   RES
);
    import smba_pkg::*;

    smba_state_t state_q;
    logic [4:0]  cnt_q;
    logic        done_q;
    smba_res_t   res_q;
    smba_res_t   res_d;
    logic [4:0]  len_d;

    // State count for an operation in the chosen mode
    function automatic logic [4:0] op_states(input smba_op_t op, input logic src_mode);
        logic [4:0] n;
        n = `SMBA_ST_SHIFT_BIN;
        case (op)
            SMBA_SHL_B, SMBA_SHL_W,                                     // [RULE1] [RULE2]
            SMBA_SRA_B, SMBA_SRA_W,                                     // [RULE3] [RULE4]
            SMBA_SRL_B, SMBA_SRL_W:                                     // [RULE5]
                n = src_mode ? `SMBA_ST_SHIFT_SRC : `SMBA_ST_SHIFT_BIN;
            SMBA_SWAP:  n = `SMBA_ST_SWAP;                              // [RULE6]
            SMBA_MULAB: n = `SMBA_ST_MULAB;                             // [RULE7]
            SMBA_MUL_B: n = src_mode ? `SMBA_ST_MULB_SRC : `SMBA_ST_MULB_BIN; // [RULE8]
            SMBA_MUL_W: n = src_mode ? `SMBA_ST_MULW_SRC : `SMBA_ST_MULW_BIN; // [RULE9]
            SMBA_DIVAB: n = `SMBA_ST_DIVAB;                             // [RULE10]
            SMBA_DIV_B: n = src_mode ? `SMBA_ST_DIVB_SRC : `SMBA_ST_DIVB_BIN; // [RULE13]
            SMBA_DIV_W: n = src_mode ? `SMBA_ST_DIVW_SRC : `SMBA_ST_DIVW_BIN; // [RULE14]
            SMBA_BCD:   n = `SMBA_ST_BCD;                               // [RULE15]
            default:    n = `SMBA_ST_SHIFT_BIN;
        endcase
        return n;
    endfunction

    // Unsigned divide; zero divisor yields all-ones quotient and keeps dividend
    function automatic logic [31:0] div16(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] q;
        logic [15:0] r;
        q = 16'hFFFF;
        r = a;
        if (b != 16'h0000)
        begin
            q = a / b;
            r = a % b;
        end
        return {q, r};
    endfunction

    // Result computed from the request every cycle, captured at start and held until the next start
    always_comb
    begin
        logic [31:0] qr;
        logic [15:0] prod;
        logic [4:0]  lo;
        logic [4:0]  hi;
        logic        cy;
        qr = 32'h0000_0000;
        prod = 16'h0000;
        lo = 5'h00;
        hi = 5'h00;
        cy = REQ.carry_flag;
        res_d = '0;
        res_d.acc = REQ.acc;
        res_d.b_reg = REQ.b_reg;
        res_d.word = REQ.dst;
        res_d.carry_flag = REQ.carry_flag;
        case (REQ.op)
            SMBA_SHL_B:
            begin
                res_d.word = {8'h00, REQ.dst[6:0], 1'b0};       // [RULE1]
                res_d.carry_flag = REQ.dst[7];                  // [RULE1]
            end
            SMBA_SHL_W:
            begin
                res_d.word = {REQ.dst[14:0], 1'b0};             // [RULE2]
                res_d.carry_flag = REQ.dst[15];                 // [RULE2]
            end
            SMBA_SRA_B:
            begin
                res_d.word = {8'h00, REQ.dst[7], REQ.dst[7:1]}; // [RULE3]
                res_d.carry_flag = REQ.dst[0];                  // [RULE3]
            end
            SMBA_SRA_W:
            begin
                res_d.word = {REQ.dst[15], REQ.dst[15:1]};      // [RULE4]
                res_d.carry_flag = REQ.dst[0];                  // [RULE4]
            end
            SMBA_SRL_B:
            begin
                res_d.word = {8'h00, 1'b0, REQ.dst[7:1]};       // [RULE5]
                res_d.carry_flag = REQ.dst[0];                  // [RULE5]
            end
            SMBA_SRL_W:
            begin
                res_d.word = {1'b0, REQ.dst[15:1]};             // [RULE5]
                res_d.carry_flag = REQ.dst[0];                  // [RULE5]
            end
            SMBA_SWAP:
                res_d.acc = {REQ.acc[3:0], REQ.acc[7:4]};       // [RULE6]
            SMBA_MULAB:
            begin
                prod = REQ.acc * REQ.b_reg;                     // [RULE7]
                res_d.b_reg = prod[15:8];
                res_d.acc = prod[7:0];
            end
            SMBA_MUL_B:
            begin
                // Widen first: a product inside a concatenation keeps only 8 bits
                prod = 16'(REQ.dst[7:0]) * 16'(REQ.src[7:0]);  // [RULE8]
                res_d.ext = {16'h0000, prod};                   // [RULE8]
            end
            SMBA_MUL_W:
                res_d.ext = REQ.dst * REQ.src;                  // [RULE9]
            SMBA_DIVAB:
            begin
                qr = div16({8'h00, REQ.acc}, {8'h00, REQ.b_reg}); // [RULE10]
                res_d.acc = qr[23:16];
                res_d.b_reg = qr[7:0];
            end
            SMBA_DIV_B:
            begin
                // Byte form: quotient in bits 15:8, remainder in 7:0
                qr = div16({8'h00, REQ.dst[7:0]}, {8'h00, REQ.src[7:0]});
                res_d.ext = {16'h0000, qr[23:16], qr[7:0]};     // [RULE11] [RULE12]
            end
            SMBA_DIV_W:
            begin
                qr = div16(REQ.dst, REQ.src);
                res_d.ext = qr;                                 // [RULE11] [RULE12]
            end
            SMBA_BCD:
            begin
                lo = {1'b0, REQ.acc[3:0]};
                hi = {1'b0, REQ.acc[7:4]};
                if (REQ.acc[3:0] > `SMBA_BCD_LIMIT || REQ.half_carry_flag)
                begin
                    lo = lo + {1'b0, `SMBA_BCD_CORR};           // [RULE15]
                    // Low carry ripples into the high nibble
                    hi = hi + {4'h0, lo[4]};
                    cy = cy | hi[4];                            // [RULE15]
                end
                if (hi[3:0] > `SMBA_BCD_LIMIT || cy || hi[4])
                begin
                    hi = {1'b0, hi[3:0]} + {1'b0, `SMBA_BCD_CORR}; // [RULE16]
                    cy = cy | hi[4];                            // [RULE18]
                end
                res_d.acc = {hi[3:0], lo[3:0]};
                res_d.carry_flag = cy;                          // [RULE18]
            end
            default:
                res_d.word = REQ.dst;
        endcase
    end

    assign len_d = op_states(REQ.op, REQ.source_mode);         // [RULE17]

    // Sequencer; start while busy is ignored
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_q <= SMBA_IDLE;
            cnt_q <= 5'h00;
        end
        else
        begin
            case (state_q)
                SMBA_IDLE:
                    if (START)
                    begin
                        cnt_q <= len_d;                         // [RULE17]
                        state_q <= SMBA_BUSY;
                    end
                SMBA_BUSY:
                    if (cnt_q == `SMBA_CNT_ONE)
                        state_q <= SMBA_IDLE;
                    else
                        cnt_q <= cnt_q - `SMBA_CNT_ONE;
                default:
                    state_q <= SMBA_IDLE;
            endcase
        end
    end

    // Completion strobe in the cycle after the last state of the count
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            done_q <= 1'b0;
        else
            done_q <= (state_q == SMBA_BUSY) && (cnt_q == `SMBA_CNT_ONE); // [RULE17]
    end

    // Result captured at start so the decoder may change the operands meanwhile
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            res_q <= '0;
        else if (START && state_q == SMBA_IDLE)
            res_q <= res_d;
    end

    assign BUSY = (state_q == SMBA_BUSY);
    assign DONE = done_q;
    assign RES  = res_q;
endmodule
`default_nettype wire

// file: smba_map.svh
`ifndef SMBA_MAP_SVH
`define SMBA_MAP_SVH
// Execution state counts, binary mode then source mode
`define SMBA_ST_SHIFT_BIN   5'h02
`define SMBA_ST_SHIFT_SRC   5'h01
`define SMBA_ST_SWAP        5'h02
`define SMBA_ST_MULAB       5'h05
`define SMBA_ST_MULB_BIN    5'h06
`define SMBA_ST_MULB_SRC    5'h05
`define SMBA_ST_MULW_BIN    5'h0C
`define SMBA_ST_MULW_SRC    5'h0B
`define SMBA_ST_DIVAB       5'h0A
`define SMBA_ST_DIVB_BIN    5'h0B
`define SMBA_ST_DIVB_SRC    5'h0A
`define SMBA_ST_DIVW_BIN    5'h15
`define SMBA_ST_DIVW_SRC    5'h14
`define SMBA_ST_BCD         5'h01
// Decimal adjust constants, then the count step
`define SMBA_BCD_LIMIT      4'h9
`define SMBA_BCD_CORR       4'h6
`define SMBA_CNT_ONE        5'h01
`endif

// file: smba_pkg.sv
`default_nettype none
package smba_pkg;
    typedef enum logic [3:0] {
        SMBA_SHL_B  = 4'h0,
        SMBA_SHL_W  = 4'h1,
        SMBA_SRA_B  = 4'h2,
        SMBA_SRA_W  = 4'h3,
        SMBA_SRL_B  = 4'h4,
        SMBA_SRL_W  = 4'h5,
        SMBA_SWAP   = 4'h6,
        SMBA_MULAB  = 4'h7,
        SMBA_MUL_B  = 4'h8,
        SMBA_MUL_W  = 4'h9,
        SMBA_DIVAB  = 4'hA,
        SMBA_DIV_B  = 4'hB,
        SMBA_DIV_W  = 4'hC,
        SMBA_BCD    = 4'hD
    } smba_op_t;

    typedef enum logic [0:0] {
        SMBA_IDLE = 1'b0,
        SMBA_BUSY = 1'b1
    } smba_state_t;

    // Request from the decoder
    typedef struct packed {
        smba_op_t    op;
        logic        source_mode;
        logic [15:0] dst;
        logic [15:0] src;
        logic [7:0]  acc;
        logic [7:0]  b_reg;
        logic        carry_flag;
        logic        half_carry_flag;
    } smba_req_t;

    // Result to the register file
    typedef struct packed {
        logic [31:0] ext;
        logic [15:0] word;
        logic [7:0]  acc;
        logic [7:0]  b_reg;
        logic        carry_flag;
    } smba_res_t;
endpackage
`default_nettype wire

// file: smba_alu_chk.sv
`default_nettype none
module smba_alu_chk
    import smba_pkg::*;
(
    input wire logic                CLK_SYS,
    input wire logic                RESET_N,
    input wire logic                START,
    input wire smba_pkg::smba_req_t REQ,
    input wire logic                BUSY,
    input wire logic                DONE,
    input wire smba_pkg::smba_res_t RES
);
    logic       take;
    logic [4:0] need_q;
    logic [4:0] cnt_q;

    // States owed by an op in the chosen mode
    function automatic logic [4:0] states(smba_op_t op, logic sm);
        case (op)
            SMBA_SWAP:  return 5'h02;
            SMBA_MULAB: return 5'h05;
            SMBA_MUL_B: return sm ? 5'h05 : 5'h06;
            SMBA_MUL_W: return sm ? 5'h0B : 5'h0C;
            SMBA_DIVAB: return 5'h0A;
            SMBA_DIV_B: return sm ? 5'h0A : 5'h0B;
            SMBA_DIV_W: return sm ? 5'h14 : 5'h15;
            SMBA_BCD:   return 5'h01;
            default:    return sm ? 5'h01 : 5'h02;
        endcase
    endfunction

    // Refused starts must not restart the count
    assign take = START && !BUSY;
    always_ff @(posedge CLK_SYS or negedge RESET_N)
        if (!RESET_N)
        begin
            need_q <= 5'h00;
            cnt_q  <= 5'h00;
        end
        else if (take)
        begin
            need_q <= states(REQ.op, REQ.source_mode);
            cnt_q  <= 5'h00;
        end
        else if (BUSY)
            cnt_q <= cnt_q + 5'h01;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    sequence s_take(op); take && REQ.op == op; endsequence

    property p_busy; take |=> BUSY; endproperty
    a_busy: assert property (p_busy) else $error("busy missing");
    property p_count; DONE |-> $past(BUSY) && cnt_q == need_q; endproperty
    a_count: assert property (p_count) else $error("bad state count");
    property p_end; $fell(BUSY) |-> DONE; endproperty
    a_end: assert property (p_end) else $error("no done at end");
    property p_pulse; DONE |=> !DONE; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_shl; s_take(SMBA_SHL_B) |=> RES.word == {8'h00, $past(REQ.dst[6:0]), 1'b0}
        && RES.carry_flag == $past(REQ.dst[7]); endproperty
    a_shl: assert property (p_shl) else $error("bad left shift");
    property p_swap; s_take(SMBA_SWAP) |=> RES.acc == {$past(REQ.acc[3:0]), $past(REQ.acc[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("bad swap");
    property p_mul; s_take(SMBA_MULAB) |=> {RES.b_reg, RES.acc} ==
        $past(REQ.acc) * $past(REQ.b_reg); endproperty
    a_mul: assert property (p_mul) else $error("bad product");
    property p_div; take && REQ.op == SMBA_DIV_W && REQ.src != 16'h0000 |=> RES.ext ==
        {$past(REQ.dst) / $past(REQ.src), $past(REQ.dst) % $past(REQ.src)}; endproperty
    a_div: assert property (p_div) else $error("bad divide");
endmodule

bind smba_alu smba_alu_chk smba_alu_chk_inst (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .START(START), .REQ(REQ), .BUSY(BUSY), .DONE(DONE), .RES(RES));
`default_nettype wire

// file: smba_dec.sv
`default_nettype none
module smba_dec
    import smba_pkg::*;
(
    input  wire logic             CLK_SYS,
    input  wire logic             DONE,
    output smba_pkg::smba_req_t   REQ,
    output logic                  START
);
    // Quiet bus before the first request
    initial
    begin
        START = 1'b0;
        REQ   = '0;
    end

    // Falling-edge driver; request spoiled once taken, poke tries a start while busy
    task automatic issue(input smba_req_t r, input int poke, output int n);
        REQ   = r;
        START = 1'b1;
        for (n = 1; n <= 40; n++)
        begin
            @(negedge CLK_SYS);
            if (DONE === 1'b1)
                break;
            START = (n == poke);
            REQ   = smba_req_t'(~r);
        end
        n = n - 1;
    endtask
endmodule
`default_nettype wire

// file: testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import smba_pkg::*;
    logic      clk_sys = 1'b0;
    logic      reset_n = 1'b0;
    logic      start;
    logic      busy;
    logic      done;
    smba_req_t req;
    smba_res_t res;
    smba_res_t s;
    int        n;
    int        mismatches = 0;
    int        cmp_count = 0;

    // Core clock, 20 ns period
    always #10 clk_sys = ~clk_sys;

    smba_alu smba_alu_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n), .START(start),
        .REQ(req), .BUSY(busy), .DONE(done), .RES(res));
    smba_dec smba_dec_inst (.CLK_SYS(clk_sys), .DONE(done), .REQ(req), .START(start));

    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One request; B comes from the low source byte; a hang ends the run
    task automatic go(input smba_op_t op, input int m, input logic [15:0] d, sr,
                      input logic [7:0] a, input logic cy = 1'b1, ac = 1'b0, input int p = 0);
        smba_dec_inst.issue('{op, m[0], d, sr, a, sr[7:0], cy, ac}, p, n);
        s = res;
        check(busy, 1'b0);
        if (n >= 40)
        begin
            check(80'h0, 80'h1);
            report_and_stop();
        end
    endtask

    // Carry in is set, so a cleared carry out is really produced
    task automatic t_shift();
        smba_op_t    ops [6] = '{SMBA_SHL_B, SMBA_SHL_W, SMBA_SRA_B, SMBA_SRA_W,
                                 SMBA_SRL_B, SMBA_SRL_W};
        logic [15:0] dst [6] = '{16'h0085, 16'h4AA2, 16'h00A3, 16'hC5A2, 16'h00A3, 16'hC5A2};
        logic [16:0] exp [6] = '{17'h1000A, 17'h09544, 17'h100D1, 17'h0E2D1,
                                 17'h10051, 17'h062D1};
        for (int i = 0; i < 12; i++)
        begin
            go(ops[i / 2], i % 2, dst[i / 2], 16'h0000, 8'h00);
            check({s.carry_flag, s.word}, exp[i / 2]);
            check(n, 2 - i % 2);
        end
        $display("shift test over");
    endtask

    // Both modes back to back; the word multiply sees a refused start
    task automatic t_arith();
        for (int m = 0; m < 2; m++)
        begin
            go(SMBA_SWAP, m, 16'h0000, 16'h0000, 8'h3C);
            check({s.acc, n[7:0]}, {8'hC3, 8'h02});
            go(SMBA_MULAB, m, 16'h0000, 16'h002D, 8'hF3);
            check({s.b_reg, s.acc, n[7:0]}, {16'h2AB7, 8'h05});
            go(SMBA_MUL_B, m, 16'h00F3, 16'h00FF, 8'h00);
            check({s.ext[15:0], n[7:0]}, {16'hF20D, 8'h06 - m[7:0]});
            go(SMBA_MUL_W, m, 16'hFFFF, 16'hFFFF, 8'h00, 1'b1, 1'b0, 3);
            check({s.ext, n[7:0]}, {32'hFFFE0001, 8'h0C - m[7:0]});
            go(SMBA_DIVAB, m, 16'h0000, 16'h000D, 8'hF3);
            check({s.acc, s.b_reg, n[7:0]}, {16'h1209, 8'h0A});
            go(SMBA_DIV_B, m, 16'h00F3, 16'h000D, 8'h00);
            check({s.ext[15:0], n[7:0]}, {16'h1209, 8'h0B - m[7:0]});
            go(SMBA_DIV_W, m, 16'h1234, 16'h0100, 8'h00);
            check({s.ext, n[7:0]}, {32'h00120034, 8'h15 - m[7:0]});
        end
        go(SMBA_DIV_W, 0, 16'h1234, 16'h0000, 8'h00);
        check(s.ext, 32'hFFFF1234);
        $display("arith test over");
    endtask

    // Inputs {carry, half carry, acc}; results {carry, acc}
    task automatic t_bcd();
        logic [9:0] in  [4] = '{10'h09A, 10'h115, 10'h245, 10'h023};
        logic [8:0] exp [4] = '{9'h100, 9'h01B, 9'h1A5, 9'h023};
        for (int i = 0; i < 8; i++)
        begin
            go(SMBA_BCD, i % 2, 16'h0000, 16'h0000, in[i / 2][7:0], in[i / 2][9], in[i / 2][8]);
            check({s.carry_flag, s.acc, n[7:0]}, {exp[i/2], 8'h01});
        end
        $display("bcd test over");
    endtask

    initial
    begin
        repeat (5) @(negedge clk_sys);
        check({busy, done, res}, 80'h0);
        reset_n = 1'b1;
        t_shift();
        t_arith();
        t_bcd();
        report_and_stop();
    end
endmodule
`default_nettype wire
